// file: src/gpio_pkg.sv
package gpio_pkg;

    // ********************************
    // pin and port geometry
    // ********************************
    localparam int              NUM_PORTS  = 4;
    localparam int              PIN_COUNT  = 23;
    localparam logic [3:0][3:0] PORT_WIDTH = {4'h2, 4'h5, 4'h8, 4'h8};
    localparam logic [3:0][4:0] PORT_BASE  = {5'h15, 5'h10, 5'h08, 5'h00};
    localparam logic [3:0][7:0] PORT_MASK  = {8'h03, 8'h1f, 8'hff, 8'hff};

    // ********************************
    // register map (byte addresses, port index in addr[1:0])
    // ********************************
    localparam logic [7:0] LATCH_BASE   = 8'h00;
    localparam logic [7:0] CFG1_BASE    = 8'h04;
    localparam logic [7:0] CFG2_BASE    = 8'h08;
    localparam logic [7:0] INPUT_BASE   = 8'h0c;
    localparam logic [7:0] AIN_DIS_ADDR = 8'h10;

    // ********************************
    // reset values and fixed pins
    // ********************************
    localparam logic [7:0] LATCH_RESET   = 8'hff;
    localparam logic [7:0] CFG1_RESET    = 8'hff;
    localparam logic [7:0] CFG2_RESET    = 8'h00;
    localparam logic [7:0] AIN_DIS_RESET = 8'h00;
    localparam logic [7:0] AIN_DIS_MASK  = 8'h3e;
    localparam int         PORT1         = 1;
    localparam logic [7:0] P1_CFG1_ONE   = 8'h2c;
    localparam logic [7:0] P1_CFG2_ZERO  = 8'h20;

    // ********************************
    // glitch suppression timing
    // ********************************
    localparam int         CLK_PERIOD_NS    = 50;
    localparam int         GLITCH_REJECT_NS = 100;
    localparam int         FILTER_CYCLES    = (GLITCH_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] FILTER_LIMIT     = 3'(FILTER_CYCLES);

    // mode = {cfg1 bit, cfg2 bit}
    typedef enum logic [1:0] {
        MODE_QUASI      = 2'h0,
        MODE_PUSH_PULL  = 2'h1,
        MODE_INPUT_ONLY = 2'h2,
        MODE_OPEN_DRAIN = 2'h3
    } io_mode_e;

    typedef struct packed {
        logic [PIN_COUNT-1:0] value;
        logic [PIN_COUNT-1:0] oe;
        logic [PIN_COUNT-1:0] weak_pullup;
    } pad_s;

    typedef struct packed {
        logic [3:0][7:0]      latch;
        logic [3:0][7:0]      cfg1;
        logic [3:0][7:0]      cfg2;
        logic [7:0]           ain_dis;
        pad_s                 pad;
        logic [PIN_COUNT-1:0] pin_in;
        logic [7:0]           rdata;
    } gpio_state_s;

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       level;
        logic [2:0] count;
    } filter_state_s;

endpackage : gpio_pkg

// file: src/pin_glitch_filter.sv
`timescale 1ns/1ns
`default_nettype none
module pin_glitch_filter
    import gpio_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic pin_i,
    output logic      level_o
);

    filter_state_s s_reg;
    filter_state_s s_next;

    // sync2 must be stable for FILTER_LIMIT cycles before the level moves;
    // this gives hysteresis in time, single-sample spikes never pass
    always_comb begin
        s_next       = s_reg;
        s_next.sync1 = pin_i;
        s_next.sync2 = s_reg.sync1;
        if (s_reg.sync2 == s_reg.level) begin
            s_next.count = 3'h0;
        end else if (s_reg.count + 3'h1 >= FILTER_LIMIT) begin // RQ9
            s_next.level = s_reg.sync2;
            s_next.count = 3'h0;
        end else begin
            s_next.count = s_reg.count + 3'h1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_o = s_reg.level;

endmodule : pin_glitch_filter
`default_nettype wire

// file: src/configurable_io_ports.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Function
// RQ1: four ports, widths 8, 8, 5, 2
// RQ2: per-pin type from two config registers
// RQ3: port1 bit5 always input-only, locked
// RQ4: port1 bits 2,3 input-only or open-drain
// RQ5: quasi: weak high, strong low
// RQ6: open-drain: no pull-ups, low when latch 0
// RQ7: input-only: no driver, high impedance
// RQ8: push-pull: strong high, same pull-down
// RQ9: every input filtered before internal use
// RQ10: software selects input-only for analog pins
// RQ11: port0 bits 1..5 input disable, reset 0
// RQ12: all pins input-only after reset
// RQ13: fixed documented two-bit type encoding
module configurable_io_ports
    import gpio_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic [7:0]           addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [7:0]           rdata_o,
    input  wire logic [PIN_COUNT-1:0] pin_i,
    output logic      [PIN_COUNT-1:0] pin_o,
    output logic      [PIN_COUNT-1:0] pin_oe_o,
    output logic      [PIN_COUNT-1:0] pin_weak_pullup_o,
    output logic      [PIN_COUNT-1:0] pin_in_o
);

    gpio_state_s          s_reg;
    gpio_state_s          s_next;
    logic [PIN_COUNT-1:0] filtered;
    logic [1:0]           port_sel;
    logic [5:0]           region;

    // ********************************
    // input conditioning
    // ********************************
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_filter
        pin_glitch_filter u_filter (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .pin_i   (pin_i[i]),
            .level_o (filtered[i])
        ); // RQ9
    end

    assign port_sel = addr_i[1:0];
    assign region   = addr_i[7:2];

    // ********************************
    // register file and pad drivers
    // ********************************
    always_comb begin
        io_mode_e   mode;
        logic [7:0] rd_word;
        int         idx;
        mode    = MODE_INPUT_ONLY;
        rd_word = 8'h00;
        idx     = 0;
        s_next  = s_reg;

        // writes; port index 3 of the address only exists within the map
        if (wr_i) begin
            if (region == LATCH_BASE[7:2]) begin
                s_next.latch[port_sel] = wdata_i & PORT_MASK[port_sel]; // RQ1
            end else if (region == CFG1_BASE[7:2]) begin
                s_next.cfg1[port_sel] = wdata_i & PORT_MASK[port_sel]; // RQ2
            end else if (region == CFG2_BASE[7:2]) begin
                s_next.cfg2[port_sel] = wdata_i & PORT_MASK[port_sel]; // RQ2
            end else if (addr_i == AIN_DIS_ADDR) begin
                s_next.ain_dis = wdata_i & AIN_DIS_MASK; // RQ11
            end
        end

        // locked pins: config bits are overridden, so software cannot move bit 5 and keeps bits 2,3 input-only or open-drain
        s_next.cfg1[PORT1] = s_next.cfg1[PORT1] | P1_CFG1_ONE; // RQ3 RQ4
        s_next.cfg2[PORT1] = s_next.cfg2[PORT1] & ~P1_CFG2_ZERO; // RQ3

        // pads follow the new latch and config at the same clock edge as a write
        s_next.pad = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (b < int'(PORT_WIDTH[p])) begin
                    idx  = int'(PORT_BASE[p]) + b;
                    mode = io_mode_e'({s_next.cfg1[p][b], s_next.cfg2[p][b]}); // RQ13
                    case (mode)
                        MODE_QUASI: begin
                            // weak high lets an outside device pull low
                            s_next.pad.weak_pullup[idx] = s_next.latch[p][b]; // RQ5
                            s_next.pad.oe[idx]          = ~s_next.latch[p][b]; // RQ5
                            s_next.pad.value[idx]       = 1'b0;
                        end
                        MODE_PUSH_PULL: begin
                            s_next.pad.oe[idx]    = 1'b1; // RQ8
                            s_next.pad.value[idx] = s_next.latch[p][b]; // RQ8
                        end
                        MODE_OPEN_DRAIN: begin
                            s_next.pad.oe[idx]    = ~s_next.latch[p][b]; // RQ6
                            s_next.pad.value[idx] = 1'b0; // RQ6
                        end
                        MODE_INPUT_ONLY: begin
                            s_next.pad.oe[idx] = 1'b0; // RQ7 RQ10
                        end
                        default: begin
                            s_next.pad.oe[idx] = 1'b0;
                        end
                    endcase
                end
            end
        end

        // digital input path; a disabled analog pin reads as zero
        s_next.pin_in        = filtered;
        s_next.pin_in[7:0]   = filtered[7:0] & ~s_reg.ain_dis; // RQ11

        // reads answer in the next cycle; unmapped addresses read zero
        if (rd_i) begin
            if (region == LATCH_BASE[7:2]) begin
                rd_word = s_reg.latch[port_sel];
            end else if (region == CFG1_BASE[7:2]) begin
                rd_word = s_reg.cfg1[port_sel];
            end else if (region == CFG2_BASE[7:2]) begin
                rd_word = s_reg.cfg2[port_sel];
            end else if (region == INPUT_BASE[7:2]) begin
                for (int b = 0; b < 8; b++) begin
                    if (b < int'(PORT_WIDTH[port_sel])) begin
                        rd_word[b] = s_reg.pin_in[int'(PORT_BASE[port_sel]) + b];
                    end
                end
            end else if (addr_i == AIN_DIS_ADDR) begin
                rd_word = s_reg.ain_dis;
            end
        end
        s_next.rdata = rd_word;
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_reg.latch   <= {NUM_PORTS{LATCH_RESET}} & PORT_MASK;
            s_reg.cfg1    <= {NUM_PORTS{CFG1_RESET}} & PORT_MASK; // RQ12
            s_reg.cfg2    <= {NUM_PORTS{CFG2_RESET}}; // RQ12
            s_reg.ain_dis <= AIN_DIS_RESET; // RQ11
            s_reg.pad     <= '0; // RQ12
            s_reg.pin_in  <= '0;
            s_reg.rdata   <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_o           = s_reg.rdata;
    assign pin_o             = s_reg.pad.value;
    assign pin_oe_o          = s_reg.pad.oe;
    assign pin_weak_pullup_o = s_reg.pad.weak_pullup;
    assign pin_in_o          = s_reg.pin_in;

endmodule : configurable_io_ports
`default_nettype wire

// file: sim/pin_environment.sv
`timescale 1ns/1ns
`default_nettype none
module pin_environment
    import gpio_pkg::*;
(
    input  wire logic [PIN_COUNT-1:0] drive_i,
    input  wire logic [PIN_COUNT-1:0] oe_i,
    input  wire logic [PIN_COUNT-1:0] ext_en_i,
    input  wire logic [PIN_COUNT-1:0] ext_val_i,
    output logic      [PIN_COUNT-1:0] level_o
);
    // board resistor pulls released lines high, open drain relies on it
    assign level_o = (oe_i & drive_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i);
endmodule : pin_environment
`default_nettype wire

// file: sim/io_ports_checker.sv
`timescale 1ns/1ns
`default_nettype none
module io_ports_checker
    import gpio_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 reset_i,
    input wire logic [7:0]           addr_i,
    input wire logic [7:0]           wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [7:0]           rdata_o,
    input wire logic [PIN_COUNT-1:0] pin_i,
    input wire logic [PIN_COUNT-1:0] pin_o,
    input wire logic [PIN_COUNT-1:0] pin_oe_o,
    input wire logic [PIN_COUNT-1:0] pin_weak_pullup_o,
    input wire logic [PIN_COUNT-1:0] pin_in_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence quiet_low;
        !pin_i[16] [*6];
    endsequence
    sequence short_pulse;
        pin_i[16] ##1 !pin_i[16];
    endsequence
    strong_high_a: assert property ((pin_o & ~pin_oe_o) == '0) else $error("high undriven");
    weak_strong_a: assert property ((pin_weak_pullup_o & pin_oe_o) == '0) else $error("weak and strong");
    reset_pin_a: assert property (!pin_oe_o[13] && !pin_weak_pullup_o[13]) else $error("reset pin driven");
    bus_pins_a: assert property ((pin_weak_pullup_o[11:10] | pin_o[11:10]) == 2'h0) else $error("bus pin high");
    released_idle_a: assert property ($fell(reset_i) |-> (pin_oe_o == '0 && pin_weak_pullup_o == '0) [*2])
        else $error("not idle after reset");
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
    disable_bits_a: assert property (rd_i && addr_i == AIN_DIS_ADDR |=> (rdata_o & ~AIN_DIS_MASK) == 8'h00)
        else $error("disable bits wrong");
    port_width_a: assert property (rd_i && addr_i == 8'h03 |=> rdata_o[7:2] == 6'h00) else $error("width wrong");
    glitch_drop_a: assert property (quiet_low ##1 short_pulse |-> ##1 !pin_in_o[16] [*5]) else $error("glitch kept");
    settle_pass_a: assert property ($stable(pin_i[16]) [*8] |-> pin_in_o[16] == pin_i[16]) else $error("input lost");
endmodule : io_ports_checker
bind configurable_io_ports io_ports_checker io_chk (.*);
`default_nettype wire

// file: sim/configurable_io_ports_test.sv
`timescale 1ns/1ns
`default_nettype none
module configurable_io_ports_test
    import gpio_pkg::*;
;
    logic                 clk_i = 1'b0;
    logic                 reset_i = 1'b1;
    logic [7:0]           addr_i = 8'h00;
    logic [7:0]           wdata_i = 8'h00;
    logic                 wr_i = 1'b0;
    logic                 rd_i = 1'b0;
    logic [7:0]           rdata_o;
    logic [PIN_COUNT-1:0] pin_i, pin_o, pin_oe_o, pin_weak_pullup_o, pin_in_o;
    logic [PIN_COUNT-1:0] ext_en = '0;
    logic [PIN_COUNT-1:0] ext_val = '0;
    int                   n_mismatch = 0;
    int                   check_count = 0;
    // {cfg1, cfg2, latch, oe, drive, weak}
    logic [5:0]           rows [8] = '{6'h04, 6'h09, 6'h14, 6'h1e, 6'h20, 6'h28, 6'h34, 6'h38};

    initial begin
        forever #25 clk_i = ~clk_i;
    end
    configurable_io_ports dut (.*);
    pin_environment far (.drive_i(pin_o), .oe_i(pin_oe_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i));

    task automatic check(input string what, input logic [PIN_COUNT-1:0] exp, input logic [PIN_COUNT-1:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : pause
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check("rdata", 23'(exp), 23'(rdata_o));
    endtask : bus_read
    task automatic test_done;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // ********
    // main sequence
    // ********
    initial begin
        repeat (6) @(posedge clk_i);
        check("oe", '0, pin_oe_o);
        check("weak", '0, pin_weak_pullup_o);
        reset_i <= 1'b0;
        bus_read(8'h04, 8'hff);
        bus_read(8'h03, 8'h03);
        bus_read(8'h10, 8'h00);
        for (int r = 0; r < 8; r++) begin
            bus_write(8'h06, {8{rows[r][5]}});
            bus_write(8'h0a, {8{rows[r][4]}});
            bus_write(8'h02, {8{rows[r][3]}});
            pause(2);
            check("oe", 23'({5{rows[r][2]}}), 23'(pin_oe_o[20:16]));
            check("drive", 23'({5{rows[r][1]}}), 23'(pin_o[20:16]));
            check("weak", 23'({5{rows[r][0]}}), 23'(pin_weak_pullup_o[20:16]));
        end
        // locked pins: push-pull asked on every port 1 pin, low latch
        bus_write(8'h05, 8'h00);
        bus_write(8'h09, 8'hff);
        bus_write(8'h01, 8'h00);
        pause(2);
        check("p1_oe", 23'hdf, 23'(pin_oe_o[15:8]));
        bus_read(8'h05, 8'h2c);
        bus_read(8'h09, 8'hdf);
        bus_write(8'h01, 8'hff);
        pause(2);
        check("p1_drive", 23'hd3, 23'(pin_o[15:8]));
        // analog pins: outputs off first, then digital inputs off
        bus_write(8'h04, 8'hff);
        bus_write(8'h10, 8'hff);
        bus_read(8'h10, 8'h3e);
        ext_en <= '1;
        ext_val <= '1;
        pause(10);
        check("p0_in", 23'hc1, 23'(pin_in_o[7:0]));
        bus_read(8'h0c, 8'hc1);
        bus_write(8'h06, 8'h00);
        bus_write(8'h0a, 8'h00);
        ext_val <= '0;
        pause(10);
        check("quasi_in", '0, 23'(pin_in_o[20:16]));
        check("quasi_weak", 23'h1f, 23'(pin_weak_pullup_o[20:16]));
        @(posedge clk_i);
        ext_val[16] <= 1'b1;
        @(posedge clk_i);
        ext_val[16] <= 1'b0;
        pause(8);
        check("glitch", '0, 23'(pin_in_o[16]));
        @(posedge clk_i);
        ext_en <= '0;
        pause(8);
        check("released", 23'h1f, 23'(pin_in_o[20:16]));
        bus_read(8'h0e, 8'h1f);
        @(posedge clk_i);
        reset_i <= 1'b1;
        pause(2);
        check("oe", '0, pin_oe_o);
        @(posedge clk_i);
        reset_i <= 1'b0;
        bus_read(8'h10, 8'h00);
        test_done;
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        n_mismatch++;
        test_done;
    end
endmodule : configurable_io_ports_test
`default_nettype wire
